// ===== logic/ldl_regs.v
// APB register bank for line driver drive levels and 10M termination
//
// The APB slave port was decided locally.
`include "ldl_defs.vh"

module ldl_regs
(
    clk_sys,
    rst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    crossed_plus_level_code,
    straight_plus_level_code,
    straight_slow_term_code,
    straight_slow_term_override_on,
    crossed_slow_term_code,
    crossed_slow_term_override_on,
    straight_plus_level_pct_x100,
    crossed_plus_level_pct_x100
);
    input  wire        clk_sys;                        // System clock, 25 MHz
    input  wire        rst;                            // Async reset, active high
    input  wire        psel;                           // APB select
    input  wire        penable;                        // APB access phase
    input  wire        pwrite;                         // APB direction
    input  wire [`LDL_ADDR_W-1:0] paddr;               // APB byte address
    input  wire [31:0] pwdata;                         // APB write data
    output reg  [31:0] prdata;                         // APB read data
    output reg         pready;                         // APB ready
    output reg         pslverr;                        // APB error, unmapped
    output reg  [5:0]  crossed_plus_level_code;        // Crossed plus-one level
    output reg  [5:0]  straight_plus_level_code;       // Straight plus-one level
    output reg  [3:0]  straight_slow_term_code;        // Straight 10M termination
    output reg         straight_slow_term_override_on; // Straight override active
    output reg  [3:0]  crossed_slow_term_code;         // Crossed 10M termination
    output reg         crossed_slow_term_override_on;  // Crossed override active
    output reg  [13:0] straight_plus_level_pct_x100;   // Straight amplitude, 0.01 %
    output reg  [13:0] crossed_plus_level_pct_x100;    // Crossed amplitude, 0.01 %

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg  [15:0] levels_q;                              // Plus-one level register
    reg  [15:0] term_q;                                // Termination register
    reg         phase_q;                               // Access phase seen, ready next

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Linear code to amplitude in hundredths of a percent, 625 per step
    function [13:0] lvl_pct;
        input [5:0] code;
        begin
            lvl_pct = code * 14'd625;
        end
    endfunction

    // Word-aligned address match
    function hit;
        input [`LDL_ADDR_W-1:0] a;
        input [11:0]            idx;
        begin
            hit = (a == {idx, 2'b00});
        end
    endfunction

    wire acc      = psel & penable & ~pready;          // One-shot access
    wire sel_lvl  = hit(paddr, `LDL_IDX_LEVELS);
    wire sel_term = hit(paddr, `LDL_IDX_TERM);
    wire sel_ana  = hit(paddr, `LDL_IDX_ANALOG);
    wire mapped   = sel_lvl | sel_term | sel_ana;

    // ----------------------------------------------------------------
    // Register writes and APB answer
    // ----------------------------------------------------------------
    // Ready one cycle into the access phase; the write lands on that edge
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            levels_q <= `LDL_LEVELS_RST;
            term_q   <= `LDL_TERM_RST;
            phase_q  <= 1'b0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            phase_q <= acc;
            if (acc & pwrite & sel_lvl)
            begin
                // Upper nibble belongs to another field set, kept zero here
                levels_q <= {4'h0, pwdata[11:0]};
            end
            if (acc & pwrite & sel_term)
            begin
                // Low six bits reserved, writes dropped
                term_q <= {pwdata[15:6], 6'h00};
            end
            // Analog register holds only reserved bits, writes dropped
            if (acc & ~pwrite)
            begin
                if (sel_lvl)
                    prdata <= {16'h0000, levels_q};
                else if (sel_term)
                    prdata <= {16'h0000, term_q};
                else
                    prdata <= 32'h00000000;
            end
            else
                prdata <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Driver-facing outputs, registered
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            crossed_plus_level_code        <= `LDL_LEVEL_RST;
            straight_plus_level_code       <= `LDL_LEVEL_RST;
            straight_slow_term_code        <= 4'h0;
            straight_slow_term_override_on <= 1'b0;
            crossed_slow_term_code         <= 4'h0;
            crossed_slow_term_override_on  <= 1'b0;
            straight_plus_level_pct_x100   <= 14'h2710;
            crossed_plus_level_pct_x100    <= 14'h2710;
        end
        else
        begin
            crossed_plus_level_code  <= levels_q[`LDL_XLVL_MSB:`LDL_XLVL_LSB];
            straight_plus_level_code <= levels_q[`LDL_SLVL_MSB:`LDL_SLVL_LSB];
            straight_plus_level_pct_x100 <= lvl_pct(levels_q[5:0]);
            crossed_plus_level_pct_x100  <= lvl_pct(levels_q[11:6]);
            // Code reaches the driver only while its override is on
            straight_slow_term_override_on <= term_q[`LDL_STERM_EN];
            straight_slow_term_code <= term_q[`LDL_STERM_EN] ?
                                       term_q[`LDL_STERM_MSB:`LDL_STERM_LSB] : 4'h0;
            crossed_slow_term_override_on <= term_q[`LDL_XTERM_EN];
            crossed_slow_term_code <= term_q[`LDL_XTERM_EN] ?
                                      term_q[`LDL_XTERM_MSB:`LDL_XTERM_LSB] : 4'h0;
        end
    end

endmodule

// ===== logic/ldl_defs.vh
// Constants for the line driver level and termination register bank
// Operation
// - Crossed plus-one level code, bits 11-6, reset 0x10
// - Straight plus-one level code, bits 5-0, reset 0x10
// - Linear code: 0x08=50%, 0x18=150%, 6.25% steps
// - Straight 10M termination code, bits 15-12, reset 0
// - Straight termination override enable, bit 11
// - Crossed 10M termination code, bits 10-7, reset 0
// - Crossed termination override enable, bit 6
// - Termination register at 0x30E, bits 5-0 read zero
// - Analog program register at 0x404, reads zero
// - Level register at 0x30C, reset 0x410
`ifndef LDL_DEFS_VH
`define LDL_DEFS_VH

// ----------------------------------------------------------------
// Register word indices (byte address is index times four)
// ----------------------------------------------------------------
`define LDL_IDX_LEVELS      12'h30C
`define LDL_IDX_TERM        12'h30E
`define LDL_IDX_ANALOG      12'h404
`define LDL_ADDR_W          14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LDL_LEVELS_RST      16'h0410
`define LDL_TERM_RST        16'h0000
`define LDL_ANALOG_RST      16'h0000
`define LDL_LEVEL_RST       6'h10
`define LDL_LEVEL_LO        6'h08
`define LDL_LEVEL_HI        6'h18
`define LDL_XLVL_MSB        11
`define LDL_XLVL_LSB        6
`define LDL_SLVL_MSB        5
`define LDL_SLVL_LSB        0
`define LDL_STERM_MSB       15
`define LDL_STERM_LSB       12
`define LDL_STERM_EN        11
`define LDL_XTERM_MSB       10
`define LDL_XTERM_LSB       7
`define LDL_XTERM_EN        6

`endif

// ===== testbench/ldl_regs_asserts.sv
// Checker on the register bank ports
module ldl_regs_asserts (
    input wire logic clk_sys, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [5:0] straight_plus_level_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic ask = psel && penable && !pready;
    wire logic hit = paddr == 14'hC30 || paddr == 14'hC38 || paddr == 14'h1010;
    wire logic wlv = pready && pwrite && paddr == 14'hC30;
    a_access_answer: assert property (ask |=> pready && pslverr == !hit) else $error("answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("idle");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper");
    a_err_no_data: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error");
    a_term_rsvd: assert property (pready && paddr == 14'hC38 |-> prdata[5:0] == 6'h0) else $error("rsvd");
    a_analog_zero: assert property (pready && paddr == 14'h1010 |-> prdata == 32'h0) else $error("analog");
    a_level_write: assert property (wlv |=> straight_plus_level_code == $past(pwdata[5:0])) else $error("level");
    cover property (wlv);
    cover property (ask && !hit);
    cover property (pready && paddr == 14'h1010);
endmodule
bind ldl_regs ldl_regs_asserts ldl_regs_asserts_i (.*);

// ===== testbench/tb_ldl_regs.sv
// Bench for the drive level register bank
module tb_ldl_regs;
    timeunit 1ns / 1ps;
    logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
    logic pready, pslverr, straight_slow_term_override_on, crossed_slow_term_override_on;
    logic [13:0] paddr = 14'h0, straight_plus_level_pct_x100, crossed_plus_level_pct_x100;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] crossed_plus_level_code, straight_plus_level_code;
    logic [3:0] straight_slow_term_code, crossed_slow_term_code;
    int bad_count = 0, n_tests = 0;
    ldl_regs ldl_regs_i (.*);
    initial forever #20 clk_sys = ~clk_sys;
    task automatic chk(logic [31:0] s, e);
        n_tests++;
        bad_count += (s !== e);
        if (s !== e) $display("MISMATCH %0t %h %h", $time, s, e);
    endtask
    task automatic complete_run;
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
        int k = 0;
        @(posedge clk_sys);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1 && ++k < 20);
        rd = prdata; er = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        bad_count += (k >= 20);
        if (k >= 20) complete_run();
    endtask
    task automatic rdc(logic [13:0] a, logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_levels;
        chk({crossed_plus_level_code, straight_plus_level_code}, 32'h410);
        chk(straight_plus_level_pct_x100, 32'h2710);
        rdc(14'hC30, 32'h410);
        rdc(14'hC38, 32'h0);
        apb(1'h1, 14'hC30, 32'hFFFFF618);
        rdc(14'hC30, 32'h618);
        chk(crossed_plus_level_pct_x100, 32'h3A98);
        apb(1'h1, 14'hC30, 32'h208);
        rdc(14'hC30, 32'h208);
        chk({crossed_plus_level_code, straight_plus_level_code}, 32'h208);
        chk(straight_plus_level_pct_x100, 32'h1388);
    endtask
    task automatic t_term;
        apb(1'h1, 14'hC38, 32'hFFFF5D7F);
        rdc(14'hC38, 32'h5D40);
        chk({straight_slow_term_override_on, straight_slow_term_code}, 32'h15);
        chk({crossed_slow_term_override_on, crossed_slow_term_code}, 32'h1A);
        apb(1'h1, 14'hC38, 32'hF780);
        apb(1'h1, 14'hC34, 32'hFFFF);
        chk({er, crossed_slow_term_override_on, crossed_slow_term_code}, 32'h20);
        apb(1'h1, 14'h1010, 32'hFFFF);
        rdc(14'h1010, 32'h0);
        rdc(14'hC30, 32'h208);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        t_levels();
        t_term();
        complete_run();
    end
endmodule
